// *** pphv_consts.svh ***
// constants of the parallel high-voltage programming port
`ifndef PPHV_CONSTS_SVH
`define PPHV_CONSTS_SVH

// command bytes
`define PPHV_CMD_NOP 8'h00
`define PPHV_CMD_CHIP_ERASE 8'h80
`define PPHV_CMD_WR_FUSE 8'h40
`define PPHV_CMD_WR_LOCK 8'h20
`define PPHV_CMD_WR_FLASH 8'h10
`define PPHV_CMD_WR_EEP 8'h11
`define PPHV_CMD_RD_SIG 8'h08
`define PPHV_CMD_RD_FUSE 8'h04
`define PPHV_CMD_RD_FLASH 8'h02
`define PPHV_CMD_RD_EEP 8'h03

// load-action codes {sel1, sel0}
`define PPHV_XA_ADDR 2'h0
`define PPHV_XA_DATA 2'h1
`define PPHV_XA_CMD 2'h2

// memory geometry
`define PPHV_FLASH_ADDR_W 14
`define PPHV_FLASH_PAGE_BITS 6
`define PPHV_EE_ADDR_W 10
`define PPHV_EE_PAGE_BITS 2

// entry signature {page latch, sel1, sel0, lower select}
`define PPHV_ENTRY_SIG 4'h0

// fuse layout and reset values
`define PPHV_KEEP_EEPROM_BIT 3
`define PPHV_FUSE_LOW_RST 8'h62
`define PPHV_FUSE_HIGH_RST 8'h99
`define PPHV_FUSE_EXT_RST 8'hff
`define PPHV_LOCK_RST 8'hff
`define PPHV_ERASED_BYTE 8'hff
`define PPHV_ERASED_WORD 16'hffff

// programming wait after each write
`define PPHV_PROG_WAIT_CYC 200

`endif

// *** pphv_pkg.sv ***
// types of the parallel high-voltage programming port
`default_nettype none

package pphv_pkg;

  typedef enum logic [6:0] {
    ST_IDLE        = 7'h01,
    ST_ERASE_FLASH = 7'h02,
    ST_ERASE_EEP   = 7'h04,
    ST_ERASE_LOCK  = 7'h08,
    ST_PROG_FLASH  = 7'h10,
    ST_PROG_EEP    = 7'h20,
    ST_WAIT        = 7'h40
  } pphv_state_e;

  typedef enum logic [1:0] {
    BSEL_LOW  = 2'h0,
    BSEL_HIGH = 2'h1,
    BSEL_EXT  = 2'h2,
    BSEL_RSVD = 2'h3
  } pphv_bsel_e;

endpackage

`default_nettype wire

// *** pphv_port.sv ***
// command, load and memory logic of the parallel high-voltage programming port
`timescale 1ns/1ps
`default_nettype none
`include "pphv_consts.svh"

// Notes on behaviour
// - flash is 256 pages of 64 words; low six bits pick the word
// - eeprom is 256 pages of 4 bytes; low two bits pick the byte
// - ready_busy_out low during erase or programming, high when ready
// - data bus driven only while read drive input is low
// - byte selects pick low, high or extended byte; other codes reserved
// - fuse read maps selects 00 low, 01 lock, 10 extended, 11 high
// - entry signature of four zero pins latched when high voltage arrives
// - crystal pulse loads address, data or command, or idles
// - write or read strobe performs the action of the held command
// - decode signature, fuse/lock, flash and eeprom read commands
// - command and address kept across many operations
// - address high byte kept until reloaded
// - chip erase clears flash, eeprom, then lock bits; fuses untouched
// - chip erase keeps eeprom when keep_eeprom_fuse programmed
// - write strobe after chip erase command starts erase, busy low
// - flash words collect in a page buffer, page programmed at once
// - write strobe after page load programs whole page, busy low
// - no-operation command resets internal write signals
module pphv_port
  import pphv_pkg::*;
#(
  parameter int FLASH_ADDR_W = `PPHV_FLASH_ADDR_W,
  parameter int FLASH_PAGE_BITS = `PPHV_FLASH_PAGE_BITS,
  parameter int EE_ADDR_W = `PPHV_EE_ADDR_W,
  parameter int EE_PAGE_BITS = `PPHV_EE_PAGE_BITS,
  parameter int PROG_WAIT_CYC = `PPHV_PROG_WAIT_CYC,
  // signature and calibration values are arbitrary
  parameter logic [7:0] SIG_BYTE0 = 8'h5a,
  parameter logic [7:0] SIG_BYTE1 = 8'h3c,
  parameter logic [7:0] SIG_BYTE2 = 8'h01,
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // programming pins
  input wire logic hv_reset_in,
  input wire logic crystal_load_strobe,
  input wire logic write_strobe_n,
  input wire logic read_drive_n,
  input wire logic lower_byte_select,
  input wire logic upper_byte_select,
  input wire logic load_action_sel0,
  input wire logic load_action_sel1,
  input wire logic page_latch_strobe,
  // data bus
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // status
  output logic ready_busy_out,
  output logic prog_mode_out
);

  // ----------------------------------------
  // checks and sizes
  // ----------------------------------------
  localparam int FLASH_WORDS = 1 << FLASH_ADDR_W;
  localparam int EE_BYTES = 1 << EE_ADDR_W;
  localparam int PAGE_WORDS = 1 << FLASH_PAGE_BITS;
  localparam int EE_PAGE_BYTES = 1 << EE_PAGE_BITS;
  localparam int SYNC_W = 17;

  generate
    if (FLASH_ADDR_W > 16 || EE_ADDR_W > 16 || FLASH_PAGE_BITS >= FLASH_ADDR_W ||
        EE_PAGE_BITS >= EE_ADDR_W || PROG_WAIT_CYC < 1 || PROG_WAIT_CYC > 65535) begin : g_bad
      $error("pphv_port: unsupported parameter values");
    end
  endgenerate

  // ----------------------------------------
  // byte select decode
  // ----------------------------------------
  function automatic pphv_bsel_e bsel(input logic upper, input logic lower);
    return pphv_bsel_e'({upper, lower});
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [3:0] strobe_prev_reg;

  assign pin_raw = {hv_reset_in, crystal_load_strobe, write_strobe_n, read_drive_n,
                    lower_byte_select, upper_byte_select, load_action_sel0, load_action_sel1,
                    page_latch_strobe, data_in};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic hv_s;
  logic xtal_s;
  logic wr_n_s;
  logic oe_n_s;
  logic bs1_s;
  logic bs2_s;
  logic [1:0] xa_s;
  logic page_latch_strobe_s;
  logic [7:0] data_s;

  assign hv_s = sync2_reg[16];
  assign xtal_s = sync2_reg[15];
  assign wr_n_s = sync2_reg[14];
  assign oe_n_s = sync2_reg[13];
  assign bs1_s = sync2_reg[12];
  assign bs2_s = sync2_reg[11];
  assign xa_s = {sync2_reg[9], sync2_reg[10]};
  assign page_latch_strobe_s = sync2_reg[8];
  assign data_s = sync2_reg[7:0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_prev_reg <= 4'h0;
    end else begin
      strobe_prev_reg <= {hv_s, xtal_s, wr_n_s, page_latch_strobe_s};
    end
  end

  logic hv_rise;
  logic xtal_rise;
  logic wr_fall;
  logic page_latch_strobe_rise;

  assign hv_rise = hv_s && !strobe_prev_reg[3];
  assign xtal_rise = xtal_s && !strobe_prev_reg[2];
  assign wr_fall = !wr_n_s && strobe_prev_reg[1];
  assign page_latch_strobe_rise = page_latch_strobe_s && !strobe_prev_reg[0];

  // ----------------------------------------
  // programming mode entry
  // ----------------------------------------
  logic prog_mode_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_mode_reg <= 1'b0;
    end else if (!hv_s) begin
      prog_mode_reg <= 1'b0;
    end else if (hv_rise) begin
      prog_mode_reg <= ({page_latch_strobe_s, xa_s, bs1_s} == `PPHV_ENTRY_SIG);
    end
  end

  assign prog_mode_out = prog_mode_reg;

  // ----------------------------------------
  // command, address and data loads
  // ----------------------------------------
  pphv_state_e state_reg;
  logic idle;
  logic [7:0] cmd_reg;
  logic [7:0] addr_low_reg;
  logic [7:0] addr_high_reg;
  logic [7:0] addr_ext_reg;
  logic [7:0] data_low_reg;
  logic [7:0] data_high_reg;
  logic page_loaded_reg;

  assign idle = prog_mode_reg && (state_reg == ST_IDLE);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_reg <= `PPHV_CMD_NOP;
      addr_low_reg <= 8'h00;
      addr_high_reg <= 8'h00;
      addr_ext_reg <= 8'h00;
      data_low_reg <= 8'h00;
      data_high_reg <= 8'h00;
    end else if (idle && xtal_rise) begin
      unique case (xa_s)
        `PPHV_XA_ADDR: begin
          unique case (bsel(bs2_s, bs1_s))
            BSEL_LOW: addr_low_reg <= data_s;
            BSEL_HIGH: addr_high_reg <= data_s;
            BSEL_EXT: addr_ext_reg <= data_s;
            BSEL_RSVD: ;
          endcase
        end
        `PPHV_XA_DATA: begin
          if (bs1_s) begin
            data_high_reg <= data_s;
          end else begin
            data_low_reg <= data_s;
          end
        end
        `PPHV_XA_CMD: cmd_reg <= data_s;
        default: ;
      endcase
    end
  end

  logic [15:0] addr_full;
  logic [FLASH_ADDR_W-FLASH_PAGE_BITS-1:0] page_index;
  logic [FLASH_PAGE_BITS-1:0] word_in_page_index;
  logic [EE_ADDR_W-EE_PAGE_BITS-1:0] ee_page_index;
  logic [EE_PAGE_BITS-1:0] ee_byte_index;

  assign addr_full = {addr_high_reg, addr_low_reg};
  assign page_index = addr_full[FLASH_ADDR_W-1:FLASH_PAGE_BITS];
  assign word_in_page_index = addr_full[FLASH_PAGE_BITS-1:0];
  assign ee_page_index = addr_full[EE_ADDR_W-1:EE_PAGE_BITS];
  assign ee_byte_index = addr_full[EE_PAGE_BITS-1:0];

  // ----------------------------------------
  // page buffers
  // ----------------------------------------
  logic [15:0] flash_buf [0:PAGE_WORDS-1];
  logic [7:0] ee_buf [0:EE_PAGE_BYTES-1];

  always_ff @(posedge clk) begin
    if (idle && page_latch_strobe_rise && cmd_reg == `PPHV_CMD_WR_FLASH) begin
      flash_buf[word_in_page_index] <= {data_high_reg, data_low_reg};
    end
    if (idle && page_latch_strobe_rise && cmd_reg == `PPHV_CMD_WR_EEP) begin
      ee_buf[ee_byte_index] <= data_low_reg;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      page_loaded_reg <= 1'b0;
    end else if (idle && page_latch_strobe_rise && cmd_reg == `PPHV_CMD_WR_FLASH) begin
      page_loaded_reg <= 1'b1;
    end else if (idle && xtal_rise && xa_s == `PPHV_XA_CMD && data_s == `PPHV_CMD_NOP) begin
      page_loaded_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // fuses and lock bits
  // ----------------------------------------
  logic [7:0] fuse_low_reg;
  logic [7:0] fuse_high_reg;
  logic [7:0] fuse_ext_reg;
  logic [7:0] lock_reg;
  logic keep_eeprom_fuse;

  assign keep_eeprom_fuse = !fuse_high_reg[`PPHV_KEEP_EEPROM_BIT];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fuse_low_reg <= `PPHV_FUSE_LOW_RST;
      fuse_high_reg <= `PPHV_FUSE_HIGH_RST;
      fuse_ext_reg <= `PPHV_FUSE_EXT_RST;
    end else if (idle && wr_fall && cmd_reg == `PPHV_CMD_WR_FUSE) begin
      unique case (bsel(bs2_s, bs1_s))
        BSEL_LOW: fuse_low_reg <= data_low_reg;
        BSEL_HIGH: fuse_high_reg <= data_low_reg;
        BSEL_EXT: fuse_ext_reg <= data_low_reg;
        BSEL_RSVD: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_reg <= `PPHV_LOCK_RST;
    end else if (state_reg == ST_ERASE_LOCK) begin
      lock_reg <= `PPHV_LOCK_RST;
    end else if (idle && wr_fall && cmd_reg == `PPHV_CMD_WR_LOCK) begin
      lock_reg <= lock_reg & data_low_reg;
    end
  end

  // ----------------------------------------
  // operation sequencer
  // ----------------------------------------
  logic [15:0] walk_reg;
  logic [15:0] wait_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      walk_reg <= 16'h0000;
      wait_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          walk_reg <= 16'h0000;
          wait_reg <= 16'(PROG_WAIT_CYC);
          if (idle && wr_fall) begin
            unique case (cmd_reg)
              `PPHV_CMD_CHIP_ERASE: state_reg <= ST_ERASE_FLASH;
              `PPHV_CMD_WR_FLASH: state_reg <= page_loaded_reg ? ST_PROG_FLASH : ST_IDLE;
              `PPHV_CMD_WR_EEP: state_reg <= ST_PROG_EEP;
              `PPHV_CMD_WR_FUSE: state_reg <= ST_WAIT;
              `PPHV_CMD_WR_LOCK: state_reg <= ST_WAIT;
              default: state_reg <= ST_IDLE;
            endcase
          end
        end
        ST_ERASE_FLASH: begin
          walk_reg <= walk_reg + 16'h0001;
          if (walk_reg == 16'(FLASH_WORDS - 1)) begin
            walk_reg <= 16'h0000;
            state_reg <= keep_eeprom_fuse ? ST_ERASE_LOCK : ST_ERASE_EEP;
          end
        end
        ST_ERASE_EEP: begin
          walk_reg <= walk_reg + 16'h0001;
          if (walk_reg == 16'(EE_BYTES - 1)) begin
            state_reg <= ST_ERASE_LOCK;
          end
        end
        ST_ERASE_LOCK: state_reg <= ST_WAIT;
        ST_PROG_FLASH: begin
          walk_reg <= walk_reg + 16'h0001;
          if (walk_reg == 16'(PAGE_WORDS - 1)) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_PROG_EEP: begin
          walk_reg <= walk_reg + 16'h0001;
          if (walk_reg == 16'(EE_PAGE_BYTES - 1)) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          wait_reg <= wait_reg - 16'h0001;
          if (wait_reg <= 16'h0001) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign ready_busy_out = (state_reg == ST_IDLE);

  // ----------------------------------------
  // memory arrays
  // ----------------------------------------
  logic [15:0] flash_mem [0:FLASH_WORDS-1];
  logic [7:0] ee_mem [0:EE_BYTES-1];

  always_ff @(posedge clk) begin
    if (state_reg == ST_ERASE_FLASH) begin
      flash_mem[walk_reg[FLASH_ADDR_W-1:0]] <= `PPHV_ERASED_WORD;
    end
    if (state_reg == ST_PROG_FLASH) begin
      flash_mem[{page_index, walk_reg[FLASH_PAGE_BITS-1:0]}] <=
        flash_buf[walk_reg[FLASH_PAGE_BITS-1:0]];
    end
  end

  always_ff @(posedge clk) begin
    if (state_reg == ST_ERASE_EEP) begin
      ee_mem[walk_reg[EE_ADDR_W-1:0]] <= `PPHV_ERASED_BYTE;
    end
    if (state_reg == ST_PROG_EEP) begin
      ee_mem[{ee_page_index, walk_reg[EE_PAGE_BITS-1:0]}] <= ee_buf[walk_reg[EE_PAGE_BITS-1:0]];
    end
  end

  // ----------------------------------------
  // read-back
  // ----------------------------------------
  logic [7:0] read_next;
  logic [15:0] flash_word;

  assign flash_word = flash_mem[addr_full[FLASH_ADDR_W-1:0]];

  always_comb begin
    read_next = 8'h00;
    unique case (cmd_reg)
      `PPHV_CMD_RD_FLASH: read_next = bs1_s ? flash_word[15:8] : flash_word[7:0];
      `PPHV_CMD_RD_EEP: read_next = ee_mem[addr_full[EE_ADDR_W-1:0]];
      `PPHV_CMD_RD_FUSE: begin
        unique case (bsel(bs2_s, bs1_s))
          BSEL_LOW: read_next = fuse_low_reg;
          BSEL_HIGH: read_next = lock_reg;
          BSEL_EXT: read_next = fuse_ext_reg;
          BSEL_RSVD: read_next = fuse_high_reg;
        endcase
      end
      `PPHV_CMD_RD_SIG: begin
        if (bs1_s) begin
          read_next = CAL_BYTE;
        end else begin
          unique case (addr_low_reg[1:0])
            2'h0: read_next = SIG_BYTE0;
            2'h1: read_next = SIG_BYTE1;
            2'h2: read_next = SIG_BYTE2;
            2'h3: read_next = 8'h00;
          endcase
        end
      end
      default: read_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_out <= read_next;
      data_oe <= prog_mode_reg && hv_s && !oe_n_s;
    end
  end

endmodule

`default_nettype wire

// *** pphv_chk_props.sv ***
// assertions on the ports of the programming port
`timescale 1ns/1ps
`default_nettype none
module pphv_chk #(
  parameter int PROG_WAIT_CYC = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // programming pins
  input wire logic hv_reset_in,
  input wire logic crystal_load_strobe,
  input wire logic write_strobe_n,
  input wire logic read_drive_n,
  input wire logic lower_byte_select,
  input wire logic upper_byte_select,
  input wire logic load_action_sel0,
  input wire logic load_action_sel1,
  input wire logic page_latch_strobe,
  // data bus
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  // status
  input wire logic ready_busy_out,
  input wire logic prog_mode_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // longest busy stretch is a full chip erase
  localparam int BUSY_MAX = 16384 + 1024 + 1 + PROG_WAIT_CYC + 16;
  wire logic [3:0] entry_pins = {page_latch_strobe, load_action_sel1, load_action_sel0, lower_byte_select};
  int busy_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) busy_cnt <= 0;
    else busy_cnt <= ready_busy_out ? 0 : busy_cnt + 1;
  end
  oe_needs_mode_a: assert property (data_oe |-> prog_mode_out)
    else $error("bus driven outside programming mode");
  oe_on_read_a: assert property ((prog_mode_out && !read_drive_n) [*6] |-> data_oe)
    else $error("bus not driven during read");
  oe_off_a: assert property (read_drive_n [*6] |-> !data_oe)
    else $error("bus driven with read drive high");
  entry_sig_a: assert property ($rose(prog_mode_out) |-> $past(entry_pins, 3) == 4'h0)
    else $error("mode entered with wrong signature");
  mode_exit_a: assert property ((!hv_reset_in) [*6] |-> !prog_mode_out)
    else $error("mode kept without high voltage");
  busy_cause_a: assert property ($fell(ready_busy_out) |-> !$past(write_strobe_n, 3))
    else $error("busy without write strobe");
  busy_mode_a: assert property ($fell(ready_busy_out) |-> prog_mode_out)
    else $error("busy outside programming mode");
  busy_bound_a: assert property (busy_cnt <= BUSY_MAX)
    else $error("busy too long");
  entry_c: cover property ($rose(prog_mode_out));
  busy_c: cover property ($fell(ready_busy_out));
  read_c: cover property ($rose(data_oe));
  erase_c: cover property (busy_cnt == 16000);
endmodule
bind pphv_port pphv_chk #(.PROG_WAIT_CYC(PROG_WAIT_CYC)) chk (.*);
`default_nettype wire

// *** pphv_prog_model.sv ***
// model of the external parallel programmer
`timescale 1ns/1ps
`default_nettype none
module pphv_prog_model #(
  parameter int BUSY_LIMIT = 20000
) (
  // clock
  input wire logic clk,
  // programming pins
  output logic hv_reset_in,
  output logic crystal_load_strobe,
  output logic write_strobe_n,
  output logic read_drive_n,
  output logic lower_byte_select,
  output logic upper_byte_select,
  output logic load_action_sel0,
  output logic load_action_sel1,
  output logic page_latch_strobe,
  // data bus and status
  output wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic ready_busy_out
);
  logic [7:0] drv_byte;
  logic drv_en;
  logic [7:0] last_byte = 8'h00;
  // released bus shows the inverse of its last level
  assign data_in = data_oe ? data_out : drv_en ? drv_byte : ~last_byte;
  always @(posedge clk) last_byte <= data_in;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic sel(input logic [1:0] xa, input logic up, input logic lo);
    {load_action_sel1, load_action_sel0} = xa;
    upper_byte_select = up;
    lower_byte_select = lo;
  endtask
  // one byte on one crystal strobe
  task automatic load(input logic [1:0] xa, input logic up, input logic lo, input logic [7:0] b);
    tick(1);
    sel(xa, up, lo);
    drv_byte = b;
    drv_en = 1'b1;
    tick(4);
    crystal_load_strobe = 1'b1;
    tick(50);
    crystal_load_strobe = 1'b0;
    tick(50);
  endtask
  task automatic latch(input logic lo);
    tick(1);
    lower_byte_select = lo;
    tick(4);
    page_latch_strobe = 1'b1;
    tick(50);
    page_latch_strobe = 1'b0;
    tick(50);
  endtask
  // write pulse, then wait for ready
  task automatic write(input logic up, input logic lo, output logic saw);
    int n;
    saw = 1'b0;
    n = 0;
    tick(1);
    sel(2'h3, up, lo);
    tick(4);
    write_strobe_n = 1'b0;
    repeat (50) begin
      tick(1);
      if (ready_busy_out === 1'b0) saw = 1'b1;
    end
    write_strobe_n = 1'b1;
    while (ready_busy_out !== 1'b1 && n < BUSY_LIMIT) begin
      tick(1);
      n++;
    end
    tick(50);
  endtask
  task automatic read(input logic up, input logic lo, output logic [7:0] v);
    tick(1);
    sel(2'h3, up, lo);
    drv_en = 1'b0;
    read_drive_n = 1'b0;
    tick(50);
    v = data_in;
    read_drive_n = 1'b1;
    tick(10);
  endtask
  // signature, high voltage, hold and settle
  task automatic enter(input logic [3:0] sig, input int wt);
    tick(1);
    {page_latch_strobe, load_action_sel1, load_action_sel0, lower_byte_select} = sig;
    tick(4);
    hv_reset_in = 1'b1;
    tick(wt);
  endtask
  task automatic leave();
    hv_reset_in = 1'b0;
    tick(20);
  endtask
  initial begin
    hv_reset_in = 1'b0;
    crystal_load_strobe = 1'b0;
    write_strobe_n = 1'b1;
    read_drive_n = 1'b1;
    page_latch_strobe = 1'b0;
    sel(2'h0, 1'b0, 1'b0);
    drv_byte = 8'h00;
    drv_en = 1'b0;
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench of the programming port
`timescale 1ns/1ps
`default_nettype none
`include "pphv_consts.svh"
module tb_top;
  // arbitrary signature and calibration values
  localparam logic [7:0] SIGS [4] = '{8'h21, 8'h43, 8'h65, 8'h87};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  wire hv_reset_in, crystal_load_strobe, write_strobe_n, read_drive_n, page_latch_strobe;
  wire lower_byte_select, upper_byte_select, load_action_sel0, load_action_sel1;
  wire data_oe, ready_busy_out, prog_mode_out;
  wire [7:0] data_in, data_out;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic saw;
  logic [7:0] v;
  pphv_port #(.PROG_WAIT_CYC(2), .SIG_BYTE0(SIGS[0]), .SIG_BYTE1(SIGS[1]),
    .SIG_BYTE2(SIGS[2]), .CAL_BYTE(SIGS[3])) dut (.*);
  pphv_prog_model p (.*);
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 98000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    p.load(2'h2, 1'b0, 1'b0, c);
  endtask
  task automatic ld(input logic [1:0] xa, input logic lo, input logic [7:0] b);
    p.load(xa, 1'b0, lo, b);
  endtask
  task automatic rc(input logic up, input logic lo, input logic [7:0] exp);
    p.read(up, lo, v);
    check(v, exp);
  endtask
  task automatic wr(input logic up, input logic lo);
    p.write(up, lo, saw);
    check({7'h0, saw}, 8'h01);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    check({6'h0, ready_busy_out, prog_mode_out}, 8'h02);
    check({7'h0, data_oe}, 8'h00);
    p.enter(4'h1, 2000);
    check({7'h0, prog_mode_out}, 8'h00);
    p.leave();
    p.enter(4'h0, 62000);
    check({7'h0, prog_mode_out}, 8'h01);
    $display("entry test done");
    cmd(`PPHV_CMD_RD_FUSE);
    ld(2'h3, 1'b0, `PPHV_CMD_RD_FLASH);
    rc(1'b0, 1'b0, `PPHV_FUSE_LOW_RST);
    rc(1'b0, 1'b1, `PPHV_LOCK_RST);
    rc(1'b1, 1'b0, `PPHV_FUSE_EXT_RST);
    rc(1'b1, 1'b1, `PPHV_FUSE_HIGH_RST);
    cmd(`PPHV_CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      ld(2'h0, 1'b0, 8'(i));
      rc(1'b0, 1'b0, SIGS[i]);
    end
    rc(1'b0, 1'b1, SIGS[3]);
    $display("read map test done");
    cmd(`PPHV_CMD_WR_FUSE);
    ld(2'h1, 1'b0, 8'h5e);
    wr(1'b0, 1'b0);
    ld(2'h1, 1'b0, 8'h91);
    wr(1'b0, 1'b1);
    ld(2'h1, 1'b0, 8'hfd);
    wr(1'b1, 1'b0);
    cmd(`PPHV_CMD_WR_LOCK);
    ld(2'h1, 1'b0, 8'hfc);
    wr(1'b0, 1'b0);
    cmd(`PPHV_CMD_RD_FUSE);
    rc(1'b0, 1'b0, 8'h5e);
    rc(1'b1, 1'b1, 8'h91);
    rc(1'b1, 1'b0, 8'hfd);
    rc(1'b0, 1'b1, 8'hfc);
    $display("fuse test done");
    cmd(`PPHV_CMD_WR_FLASH);
    ld(2'h0, 1'b1, 8'h01);
    ld(2'h0, 1'b0, 8'h05);
    ld(2'h1, 1'b0, 8'h34);
    ld(2'h1, 1'b1, 8'h12);
    p.latch(1'b1);
    ld(2'h0, 1'b0, 8'h06);
    ld(2'h1, 1'b0, 8'h78);
    ld(2'h1, 1'b1, 8'h56);
    p.latch(1'b1);
    wr(1'b0, 1'b0);
    cmd(`PPHV_CMD_NOP);
    cmd(`PPHV_CMD_WR_FLASH);
    p.write(1'b0, 1'b0, saw);
    check({7'h0, saw}, 8'h00);
    cmd(`PPHV_CMD_RD_FLASH);
    ld(2'h0, 1'b0, 8'h05);
    rc(1'b0, 1'b0, 8'h34);
    rc(1'b0, 1'b1, 8'h12);
    ld(2'h0, 1'b0, 8'h06);
    rc(1'b0, 1'b0, 8'h78);
    rc(1'b0, 1'b1, 8'h56);
    $display("flash test done");
    cmd(`PPHV_CMD_WR_EEP);
    ld(2'h0, 1'b1, 8'h02);
    ld(2'h0, 1'b0, 8'h07);
    ld(2'h1, 1'b0, 8'ha5);
    p.latch(1'b0);
    wr(1'b0, 1'b0);
    cmd(`PPHV_CMD_RD_EEP);
    rc(1'b0, 1'b0, 8'ha5);
    $display("eeprom test done");
    cmd(`PPHV_CMD_CHIP_ERASE);
    wr(1'b0, 1'b0);
    cmd(`PPHV_CMD_RD_EEP);
    rc(1'b0, 1'b0, 8'ha5);
    cmd(`PPHV_CMD_RD_FLASH);
    ld(2'h0, 1'b1, 8'h01);
    ld(2'h0, 1'b0, 8'h05);
    rc(1'b0, 1'b0, `PPHV_ERASED_BYTE);
    cmd(`PPHV_CMD_RD_FUSE);
    rc(1'b0, 1'b1, `PPHV_LOCK_RST);
    rc(1'b1, 1'b1, 8'h91);
    $display("erase test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
